// ---- rtl/cpm_top.sv ----
// Clock selection, divider and power-mode control with AXI4-Lite regs.
// Assumes oscillator status and wake inputs are asynchronous levels.
// Operation
// - three-bit code divides system clock by powers
// - two-bit field picks which fast oscillators start
// - both started: RC first, crystal once running
// - new start code acts after wake from deep, memory or register retention modes, not standby
// - enable bit gates crystal-ready interrupt and wakeup
// - bypass takes clock from pin, oscillators off
// - keep bit leaves crystal on in register retention
// - three-bit field selects low-frequency clock source
// - status bit shows low-frequency clock ready
// - status bit shows crystal sources system clock
// - crystal and synthesised slow clock stop asleep except in standby or in register retention with keep bit
// - hold system until selected slow clock runs
// - wake cause flags for pin, tick, comparator
// - flags clear on read and on power-down
// - nonzero mode write other than reserved 5 or 6 enters that power-down mode
// - mode field reads back the previous mode
// - register retention timers follow slow clock choice
`timescale 1ns/1ps
`default_nettype none
module cpm_top
#(
  parameter int ADDR_W = 12
)
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address and data
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Oscillator status
  input wire logic fast_crystal_osc_running,
  input wire logic fast_rc_osc_running,
  input wire logic low_freq_clock_running,
  input wire logic low_freq_clock,
  // Wake sources
  input wire logic wake_pin,
  input wire logic wake_tick,
  input wire logic wake_cmp,
  // Oscillator control
  output logic fast_crystal_osc_en,
  output logic fast_rc_osc_en,
  output logic [2:0] low_freq_src_sel,
  output logic low_freq_synth_en,
  // System clock control
  output logic [1:0] sys_clk_src,
  output logic mcu_clk_en,
  output logic mcu_run,
  // Power state
  output logic [2:0] pd_mode,
  output logic reg_ret_timers_on,
  output logic fast_crystal_ready_irq
);

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  logic [cpm_pkg::SY_N-1:0] sy1_r;
  logic [cpm_pkg::SY_N-1:0] sy2_r;
  wire [cpm_pkg::SY_N-1:0] sy_in;

  assign sy_in = {wake_cmp, wake_tick, wake_pin, low_freq_clock,
                  low_freq_clock_running, fast_rc_osc_running,
                  fast_crystal_osc_running};

  genvar gi;
  generate
    for (gi = 0; gi < cpm_pkg::SY_N; gi++)
    begin : g_sync
      always_ff @(posedge aclk)
      begin
        if (!aresetn)
        begin
          sy1_r[gi] <= 1'b0;
          sy2_r[gi] <= 1'b0;
        end
        else
        begin
          sy1_r[gi] <= sy_in[gi];
          sy2_r[gi] <= sy1_r[gi];
        end
      end
    end
  endgenerate

  wire xrun_s = sy2_r[cpm_pkg::SY_XRUN];
  wire lfrun_s = sy2_r[cpm_pkg::SY_LFRUN];
  wire lfph_s = sy2_r[cpm_pkg::SY_LFPH];
  wire [2:0] wake_s = {sy2_r[cpm_pkg::SY_WPIN], sy2_r[cpm_pkg::SY_WTICK],
                       sy2_r[cpm_pkg::SY_WCMP]};

  // ----------------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------------
  logic aw_v_r;
  logic w_v_r;
  logic [ADDR_W-1:0] aw_a_r;
  logic [7:0] wd_r;
  logic ws_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic rvalid_r;
  logic [1:0] rresp_r;
  logic [7:0] rdata_r;

  assign s_axi_awready = !aw_v_r && !bvalid_r;
  assign s_axi_wready = !w_v_r && !bvalid_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = !rvalid_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rresp = rresp_r;
  assign s_axi_rdata = {24'h000000, rdata_r};

  wire wr_fire = aw_v_r && w_v_r && !bvalid_r;
  wire rd_fire = s_axi_arvalid && !rvalid_r;
  wire [cpm_pkg::IDX_W-1:0] w_idx =
    aw_a_r[cpm_pkg::ADDR_LSB +: cpm_pkg::IDX_W];
  wire [cpm_pkg::IDX_W-1:0] r_idx =
    s_axi_araddr[cpm_pkg::ADDR_LSB +: cpm_pkg::IDX_W];
  wire w_hi0 = (aw_a_r >> (cpm_pkg::ADDR_LSB + cpm_pkg::IDX_W)) == '0;
  wire r_hi0 = (s_axi_araddr >> (cpm_pkg::ADDR_LSB + cpm_pkg::IDX_W)) == '0;
  wire wr_clk = wr_fire && w_hi0 && (w_idx == cpm_pkg::IDX_CLK) && ws_r;
  wire wr_pwr = wr_fire && w_hi0 && (w_idx == cpm_pkg::IDX_PWR) && ws_r;
  wire wr_lf = wr_fire && w_hi0 && (w_idx == cpm_pkg::IDX_LF) && ws_r;
  wire w_map = w_hi0 && (w_idx == cpm_pkg::IDX_CLK ||
                         w_idx == cpm_pkg::IDX_PWR ||
                         w_idx == cpm_pkg::IDX_LF);
  wire rd_clk = r_hi0 && (r_idx == cpm_pkg::IDX_CLK);
  wire rd_pwr = r_hi0 && (r_idx == cpm_pkg::IDX_PWR);
  wire rd_lf = r_hi0 && (r_idx == cpm_pkg::IDX_LF);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_v_r <= 1'b0;
      w_v_r <= 1'b0;
      aw_a_r <= '0;
      wd_r <= 8'h00;
      ws_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= cpm_pkg::RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_v_r <= 1'b1;
        aw_a_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_v_r <= 1'b1;
        wd_r <= s_axi_wdata[7:0];
        ws_r <= s_axi_wstrb[0];
      end
      if (wr_fire)
      begin
        aw_v_r <= 1'b0;
        w_v_r <= 1'b0;
        bvalid_r <= 1'b1;
        bresp_r <= w_map ? cpm_pkg::RESP_OKAY : cpm_pkg::RESP_SLVERR;
      end
      else if (bvalid_r && s_axi_bready)
      begin
        bvalid_r <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Registers and power-mode state
  // ----------------------------------------------------------------
  logic [7:0] clk_cfg_r;
  logic [2:0] lf_src_r;
  logic [1:0] osc_act_r;
  logic [2:0] mode_r;
  logic [2:0] prev_mode_r;
  logic [2:0] flags_r;
  logic [2:0] flags_nxt;
  logic xtal_sel_r;
  logic xrun_prev_r;
  logic xirq_r;
  cpm_pkg::cpm_state_t state_r;
  cpm_pkg::cpm_state_t state_nxt;

  wire byp = clk_cfg_r[cpm_pkg::CLK_BYP];
  wire [1:0] osc_cfg = clk_cfg_r[cpm_pkg::CLK_OSC_HI:cpm_pkg::CLK_OSC_LO];
  wire asleep = (state_r == cpm_pkg::ST_SLEEP);
  wire lf_none = (lf_src_r == cpm_pkg::LF_NONE);
  wire lf_active = !lf_none && (lf_src_r != cpm_pkg::LF_RSV5) &&
                   (lf_src_r != cpm_pkg::LF_RSV6);
  wire lf_ready = lf_active && lfrun_s;
  wire lf_ok = lf_none || lfrun_s;
  wire xrise = xrun_s && !xrun_prev_r;
  wire xirq_ev = xrise && clk_cfg_r[cpm_pkg::CLK_XIRQ];
  wire [2:0] wk_mask = (mode_r == cpm_pkg::PD_STBY) ? 3'h6 : 3'h7;
  wire [2:0] wk_hit = wake_s & wk_mask;
  wire wake = asleep && ((|wk_hit) || xirq_ev);
  wire pd_req = (state_r == cpm_pkg::ST_RUN) && wr_pwr &&
                (wd_r[2:0] != cpm_pkg::PD_NONE) &&
                (wd_r[2:0] != cpm_pkg::PD_RSV5) &&
                (wd_r[2:0] != cpm_pkg::PD_RSV6);
  wire retained = (mode_r == cpm_pkg::PD_DEEP) ||
                  (mode_r == cpm_pkg::PD_MEM_OFF) ||
                  (mode_r == cpm_pkg::PD_MEM_ON) ||
                  (mode_r == cpm_pkg::PD_REG);

  // Read clear and power-down clear lose against a new wake cause
  always_comb
  begin
    flags_nxt = flags_r;
    if ((rd_fire && rd_pwr) || pd_req)
      flags_nxt = 3'h0;
    if (wake)
      flags_nxt = flags_nxt | wk_hit;
  end

  always_comb
  begin
    state_nxt = state_r;
    unique case (state_r)
      cpm_pkg::ST_WAIT_LF: if (lf_ok) state_nxt = cpm_pkg::ST_RUN;
      cpm_pkg::ST_RUN: if (pd_req) state_nxt = cpm_pkg::ST_SLEEP;
      cpm_pkg::ST_SLEEP: if (wake) state_nxt = cpm_pkg::ST_WAIT_LF;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_r <= cpm_pkg::ST_WAIT_LF;
      clk_cfg_r <= cpm_pkg::CLK_RST;
      lf_src_r <= cpm_pkg::LF_RST;
      osc_act_r <= cpm_pkg::OSC_BOTH;
      mode_r <= cpm_pkg::PD_NONE;
      prev_mode_r <= cpm_pkg::PD_NONE;
      flags_r <= 3'h0;
      xrun_prev_r <= 1'b0;
      xirq_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      flags_r <= flags_nxt;
      xrun_prev_r <= xrun_s;
      xirq_r <= xirq_ev;
      if (wr_clk)
        clk_cfg_r <= wd_r;
      if (wr_lf)
        lf_src_r <= wd_r[2:0];
      if (pd_req)
        mode_r <= wd_r[2:0];
      if (wake)
      begin
        prev_mode_r <= mode_r;
        if (retained)
          osc_act_r <= osc_cfg;
      end
    end
  end

  // ----------------------------------------------------------------
  // Oscillator and clock source control
  // ----------------------------------------------------------------
  wire run_xen = !byp && (osc_act_r != cpm_pkg::OSC_RC);
  wire run_ren = !byp && (osc_act_r != cpm_pkg::OSC_XTAL);
  wire sleep_off = asleep && (mode_r != cpm_pkg::PD_STBY);
  wire keep_x = (mode_r == cpm_pkg::PD_REG) &&
                clk_cfg_r[cpm_pkg::CLK_KEEPX];

  assign fast_crystal_osc_en = run_xen && (!sleep_off || keep_x);
  assign fast_rc_osc_en = run_ren && !sleep_off;
  assign low_freq_src_sel = lf_src_r;
  assign low_freq_synth_en = (lf_src_r == cpm_pkg::LF_SYNTH) &&
                             xrun_s && fast_crystal_osc_en;

  // Crystal takes over only after it reports running
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      xtal_sel_r <= 1'b0;
    else
      xtal_sel_r <= xrun_s && fast_crystal_osc_en && !byp;
  end

  cpm_div_if dvi ();

  assign dvi.div_code = clk_cfg_r[cpm_pkg::DIV_W-1:0];
  assign dvi.src_req = cpm_pkg::cpm_src_t'(byp ? cpm_pkg::SRC_PIN :
                       (xtal_sel_r ? cpm_pkg::SRC_XTAL
                                   : cpm_pkg::SRC_RC));

  cpm_clk_div u_div
  (
    .aclk(aclk),
    .aresetn(aresetn),
    .dv(dvi.div)
  );

  assign sys_clk_src = dvi.src;
  assign mcu_run = (state_r == cpm_pkg::ST_RUN);
  assign mcu_clk_en = dvi.tick && mcu_run;
  assign pd_mode = asleep ? mode_r : cpm_pkg::PD_NONE;
  assign reg_ret_timers_on = asleep && (mode_r == cpm_pkg::PD_REG) &&
                             lf_active;
  assign fast_crystal_ready_irq = xirq_r;

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  wire [7:0] pwr_rd = {flags_r, 2'b00, prev_mode_r};
  wire [7:0] lf_rd = {lfph_s, lf_ready, 2'b00, xtal_sel_r, lf_src_r};
  wire [7:0] rd_mux = rd_clk ? clk_cfg_r :
                      (rd_pwr ? pwr_rd : (rd_lf ? lf_rd : 8'h00));

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_r <= 1'b0;
      rdata_r <= 8'h00;
      rresp_r <= cpm_pkg::RESP_OKAY;
    end
    else if (rd_fire)
    begin
      rvalid_r <= 1'b1;
      rdata_r <= rd_mux;
      rresp_r <= (rd_clk || rd_pwr || rd_lf) ? cpm_pkg::RESP_OKAY
                                            : cpm_pkg::RESP_SLVERR;
    end
    else if (rvalid_r && s_axi_rready)
    begin
      rvalid_r <= 1'b0;
    end
  end

endmodule // cpm_top
`default_nettype wire

// ---- rtl/cpm_pkg.sv ----
// Constants and types of the clock and power-mode controller.
// Assumes nothing of its surroundings; used as cpm_pkg::name only.
package cpm_pkg;

  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam int IDX_W = 8;
  localparam int ADDR_LSB = 2;
  localparam logic [7:0] IDX_CLK = 8'hA3;
  localparam logic [7:0] IDX_PWR = 8'hA4;
  localparam logic [7:0] IDX_LF = 8'hAD;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int CLK_KEEPX = 7;
  localparam int CLK_BYP = 6;
  localparam int CLK_OSC_HI = 5;
  localparam int CLK_OSC_LO = 4;
  localparam int CLK_XIRQ = 3;
  localparam int DIV_W = 3;
  localparam int DIV_CNT_W = 7;
  localparam logic [7:0] CLK_RST = 8'h00;
  localparam logic [2:0] LF_RST = 3'h7;

  // ----------------------------------------------------------------
  // Encodings
  // ----------------------------------------------------------------
  localparam logic [2:0] PD_NONE = 3'h0;
  localparam logic [2:0] PD_DEEP = 3'h1;
  localparam logic [2:0] PD_MEM_OFF = 3'h2;
  localparam logic [2:0] PD_MEM_ON = 3'h3;
  localparam logic [2:0] PD_REG = 3'h4;
  localparam logic [2:0] PD_RSV5 = 3'h5;
  localparam logic [2:0] PD_RSV6 = 3'h6;
  localparam logic [2:0] PD_STBY = 3'h7;
  localparam logic [1:0] OSC_BOTH = 2'h0;
  localparam logic [1:0] OSC_RC = 2'h1;
  localparam logic [1:0] OSC_XTAL = 2'h2;
  localparam logic [2:0] LF_SYNTH = 3'h2;
  localparam logic [2:0] LF_RSV5 = 3'h5;
  localparam logic [2:0] LF_RSV6 = 3'h6;
  localparam logic [2:0] LF_NONE = 3'h7;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Synchroniser lanes
  localparam int SY_XRUN = 0;
  localparam int SY_RCRUN = 1;
  localparam int SY_LFRUN = 2;
  localparam int SY_LFPH = 3;
  localparam int SY_WPIN = 4;
  localparam int SY_WTICK = 5;
  localparam int SY_WCMP = 6;
  localparam int SY_N = 7;

  typedef enum logic [1:0] {SRC_RC, SRC_XTAL, SRC_PIN} cpm_src_t;
  typedef enum logic [1:0] {ST_WAIT_LF, ST_RUN, ST_SLEEP} cpm_state_t;

endpackage

// ---- rtl/cpm_div_if.sv ----
// Link between the controller and its clock divider.
// Assumes the controller drives requests, the divider answers ticks.
`timescale 1ns/1ps
`default_nettype none
interface cpm_div_if;
  logic [cpm_pkg::DIV_W-1:0] div_code;
  cpm_pkg::cpm_src_t src_req;
  cpm_pkg::cpm_src_t src;
  logic tick;
  modport ctl (output div_code, output src_req, input src, input tick);
  modport div (input div_code, input src_req, output src, output tick);
endinterface
`default_nettype wire

// ---- rtl/cpm_clk_div.sv ----
// Divider of the system clock and holder of the clock source.
// Assumes requests come from logic on aclk.
`timescale 1ns/1ps
`default_nettype none
module cpm_clk_div
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Controller side
  cpm_div_if.div dv
);

  logic [cpm_pkg::DIV_CNT_W-1:0] cnt_r;
  logic [cpm_pkg::DIV_W-1:0] code_r;
  cpm_pkg::cpm_src_t src_r;
  wire [cpm_pkg::DIV_CNT_W-1:0] mask;
  wire tick;

  assign mask = ~({cpm_pkg::DIV_CNT_W{1'b1}} << code_r);
  assign tick = (cnt_r == mask);
  assign dv.tick = tick;
  assign dv.src = src_r;

  // Changes land only at a period end, so no pulse is cut short
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cnt_r <= '0;
      code_r <= '0;
      src_r <= cpm_pkg::SRC_RC;
    end
    else if (tick)
    begin
      cnt_r <= '0;
      code_r <= dv.div_code;
      src_r <= dv.src_req;
    end
    else
    begin
      cnt_r <= cnt_r + 1'b1;
    end
  end

endmodule // cpm_clk_div
`default_nettype wire

// ---- dv/cpm_osc_model.sv ----
// Behavioural oscillators facing the clock and power-mode controller.
// Assumes enables come from the controller; start-up times in cycles.
`timescale 1ns/1ps
`default_nettype none
module cpm_osc_model
#(
  parameter int XT_DLY = 30,
  parameter int RC_DLY = 4,
  parameter int LF_DLY = 12
)
(
  // Clock
  input wire logic aclk,
  // Controls
  input wire logic xt_en,
  input wire logic rc_en,
  input wire logic [2:0] lf_sel,
  input wire logic synth_en,
  // Status
  output logic xt_run,
  output logic rc_run,
  output logic lf_run,
  output logic lf_clk
);
  int xt_n = 0;
  int rc_n = 0;
  int lf_n = 0;
  logic [2:0] ph = 3'h0;
  logic lf_ok;
  // Synthesised slow clock dies with the crystal
  assign lf_ok = (lf_sel == 3'h2) ? (synth_en && xt_run)
               : (lf_sel < 3'h5);
  assign xt_run = xt_n == XT_DLY;
  assign rc_run = rc_n == RC_DLY;
  assign lf_run = lf_n == LF_DLY;
  // Slow clock stands low when not running
  assign lf_clk = lf_run && ph[2];
  always @(posedge aclk)
  begin
    xt_n <= !xt_en ? 0 : (xt_run ? xt_n : xt_n + 1);
    rc_n <= !rc_en ? 0 : (rc_run ? rc_n : rc_n + 1);
    lf_n <= !lf_ok ? 0 : (lf_run ? lf_n : lf_n + 1);
    ph <= lf_run ? ph + 3'h1 : 3'h0;
  end
endmodule // cpm_osc_model
`default_nettype wire

// ---- dv/cpm_top_sva.sv ----
// Port-level checker of the clock and power-mode controller.
// Assumes it is bound into cpm_top and sees its ports only.
`timescale 1ns/1ps
`default_nettype none
module cpm_top_sva
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Watched ports
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic fast_crystal_osc_running,
  input wire logic low_freq_clock_running,
  input wire logic fast_crystal_osc_en,
  input wire logic [2:0] low_freq_src_sel,
  input wire logic low_freq_synth_en,
  input wire logic mcu_clk_en,
  input wire logic mcu_run,
  input wire logic [2:0] pd_mode,
  input wire logic reg_ret_timers_on,
  input wire logic fast_crystal_ready_irq
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  sequence irq_seen;
    fast_crystal_ready_irq ##1 !fast_crystal_ready_irq;
  endsequence
  a_clk_gated: assert property (mcu_clk_en |-> mcu_run)
    else $error("clock enable while held");
  a_sleep_held: assert property (pd_mode != 3'h0 |-> !mcu_run)
    else $error("running while asleep");
  a_xtal_off: assert property (pd_mode inside {3'h1, 3'h2, 3'h3}
    |-> !fast_crystal_osc_en && !low_freq_synth_en)
    else $error("crystal kept in deep modes");
  a_ret_timers: assert property (reg_ret_timers_on ==
    (pd_mode == 3'h4 && low_freq_src_sel <= 3'h4))
    else $error("retention timers wrong");
  a_synth_sel: assert property (low_freq_synth_en
    |-> low_freq_src_sel == 3'h2)
    else $error("synth on without select");
  a_irq_pulse: assert property (fast_crystal_ready_irq |-> irq_seen)
    else $error("irq longer than a cycle");
  a_irq_cause: assert property (fast_crystal_ready_irq
    |-> $past(fast_crystal_osc_running, 2))
    else $error("irq without crystal");
  a_run_lf: assert property ($rose(mcu_run) |->
    low_freq_src_sel == 3'h7 || $past(low_freq_clock_running, 2))
    else $error("released before slow clock");
  a_read_hold: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
endmodule // cpm_top_sva
bind cpm_top cpm_top_sva u_cpm_top_sva (.aclk, .aresetn, .s_axi_rvalid,
  .s_axi_rready, .s_axi_rdata, .fast_crystal_osc_running,
  .low_freq_clock_running, .fast_crystal_osc_en, .low_freq_src_sel,
  .low_freq_synth_en, .mcu_clk_en, .mcu_run, .pd_mode,
  .reg_ret_timers_on, .fast_crystal_ready_irq);
`default_nettype wire

// ---- dv/testbench.sv ----
// Self-checking bench of the clock and power-mode controller.
// Assumes cpm_top, the oscillator model and the bound checker.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam logic [11:0] A_CLK = {2'h0, cpm_pkg::IDX_CLK, 2'h0};
  localparam logic [11:0] A_PWR = {2'h0, cpm_pkg::IDX_PWR, 2'h0};
  localparam logic [11:0] A_LF = {2'h0, cpm_pkg::IDX_LF, 2'h0};
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [11:0] awaddr = 12'h0, araddr = 12'h0;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic [2:0] wk = 3'h0;
  logic awready, wready, bvalid, arready, rvalid, xe, re;
  logic [1:0] bresp, rresp, r, sys_src;
  logic [31:0] rdata;
  logic xt_run, rc_run, lf_run, lf_clk, xt_en, rc_en, synth_en;
  logic [2:0] lf_sel, pd_mode;
  logic clk_en, run, timers_on, irq;
  logic [7:0] d;
  logic [2:0] modes [5] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h7};
  logic [2:0] wsrc [5] = '{3'h4, 3'h2, 3'h1, 3'h2, 3'h4};
  logic [1:0] codes [3] = '{2'h1, 2'h2, 2'h0};
  int mismatches = 0, n_checks = 0, irq_cnt = 0, cnt, i, k;
  always #2 aclk = ~aclk;
  always @(posedge aclk) if (irq === 1'b1) irq_cnt <= irq_cnt + 1;
  cpm_top u_cpm_top (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .fast_crystal_osc_running(xt_run),
    .fast_rc_osc_running(rc_run), .low_freq_clock_running(lf_run),
    .low_freq_clock(lf_clk), .wake_pin(wk[2]), .wake_tick(wk[1]),
    .wake_cmp(wk[0]), .fast_crystal_osc_en(xt_en), .fast_rc_osc_en(rc_en),
    .low_freq_src_sel(lf_sel), .low_freq_synth_en(synth_en),
    .sys_clk_src(sys_src), .mcu_clk_en(clk_en), .mcu_run(run),
    .pd_mode(pd_mode), .reg_ret_timers_on(timers_on),
    .fast_crystal_ready_irq(irq));
  cpm_osc_model u_cpm_osc_model (.aclk(aclk), .xt_en(xt_en),
    .rc_en(rc_en), .lf_sel(lf_sel), .synth_en(synth_en), .xt_run(xt_run),
    .rc_run(rc_run), .lf_run(lf_run), .lf_clk(lf_clk));
  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[ERR] %0t got %0h expected %0h", $time, got, exp);
    end
  endtask
  // Ends on a falling edge so samples are settled
  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
    @(negedge aclk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] v,
                    output logic [1:0] rs);
    logic aw_hs, w_hs, b_hs;
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'h0, v};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    b_hs = 1'b0;
    while (!b_hs)
    begin
      @(negedge aclk);
      aw_hs = awvalid && awready;
      w_hs = wvalid && wready;
      b_hs = bvalid;
      rs = bresp;
      @(posedge aclk);
      if (aw_hs) awvalid <= 1'b0;
      if (w_hs) wvalid <= 1'b0;
    end
    chk({awvalid, wvalid}, 2'b00);
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, output logic [7:0] v,
                    output logic [1:0] rs);
    logic ar_hs, r_hs;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    r_hs = 1'b0;
    while (!r_hs)
    begin
      @(negedge aclk);
      ar_hs = arvalid && arready;
      r_hs = rvalid;
      v = rdata[7:0];
      rs = rresp;
      @(posedge aclk);
      if (ar_hs) arvalid <= 1'b0;
    end
    chk(arvalid, 0);
    rready <= 1'b0;
  endtask
  task automatic wo(input logic [11:0] a, input logic [7:0] v);
    wr(a, v, r);
    chk(r, cpm_pkg::RESP_OKAY);
  endtask
  task automatic rchk(input logic [11:0] a, input logic [7:0] e, m);
    rd(a, d, r);
    chk(d & m, e);
    chk(r, cpm_pkg::RESP_OKAY);
  endtask
  task automatic go_sleep(input logic [2:0] m);
    wo(A_PWR, {5'h0, m});
    cyc(2);
    chk(pd_mode, m);
    chk(run, 0);
  endtask
  task automatic wake(input logic [2:0] b, input logic hold);
    @(posedge aclk);
    wk <= b;
    if (hold)
    begin
      cyc(10);
      chk(run, 0);
    end
    for (int n = 0; n < 200 && run !== 1'b1; n++) cyc(0);
    chk(run, 1);
    @(posedge aclk);
    wk <= 3'h0;
    cyc(4);
  endtask
  initial
  begin
    repeat (40000) @(posedge aclk);
    mismatches++;
    stop_test;
  end
  initial
  begin
    xe = 1'b1;
    re = 1'b1;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    cyc(1);
    chk(xt_en, 1);
    chk(sys_src, 0);
    rchk(A_CLK, 8'h00, 8'hFF);
    rchk(A_PWR, 8'h00, 8'hFF);
    rchk(A_LF, 8'h07, 8'h7F);
    for (k = 0; k < 100 && sys_src !== 2'h1; k++) cyc(0);
    chk(sys_src, 1);
    rchk(A_LF, 8'h0F, 8'h7F);
    $display("test reset done");
    for (i = 0; i < 8; i++)
    begin
      wo(A_CLK, i[7:0]);
      cyc(300);
      cnt = 0;
      repeat (1024)
      begin
        @(negedge aclk);
        if (clk_en === 1'b1) cnt++;
      end
      chk(cnt, 1024 >> i);
    end
    wo(A_CLK, 8'h00);
    $display("test divide done");
    for (i = 0; i < 5; i++)
    begin
      if (modes[i] == 3'h1) chk(rc_run, 1);
      go_sleep(modes[i]);
      wake(wsrc[i], 1'b0);
      if (i % 2 == 1 || i == 4)
      begin
        rchk(A_PWR, {wsrc[i], 2'h0, modes[i]}, 8'hFF);
        rchk(A_PWR, {5'h0, modes[i]}, 8'hFF);
      end
    end
    wo(A_PWR, 8'h05);
    cyc(4);
    chk(run, 1);
    wo(A_PWR, 8'h00);
    wr(12'h2B8, 8'h55, r);
    chk(r, cpm_pkg::RESP_SLVERR);
    rd(12'h2B8, d, r);
    chk(r, cpm_pkg::RESP_SLVERR);
    $display("test power done");
    for (i = 0; i < 3; i++)
    begin
      wo(A_CLK, {2'h0, codes[i], 4'h0});
      chk(xt_en, xe);
      chk(rc_en, re);
      go_sleep(3'h2);
      wake(3'h4, 1'b0);
      xe = codes[i] != 2'h1;
      re = codes[i] != 2'h2;
      chk(xt_en, xe);
      chk(rc_en, re);
      wo(A_PWR, 8'h00);
    end
    cyc(60);
    chk(irq_cnt, 0);
    wo(A_CLK, 8'h08);
    go_sleep(3'h2);
    wake(3'h4, 1'b0);
    cyc(60);
    chk(irq_cnt, 1);
    wo(A_CLK, 8'h40);
    cyc(20);
    chk(sys_src, 2);
    chk(xt_en, 0);
    wo(A_CLK, 8'h80);
    go_sleep(3'h4);
    chk(xt_en, 1);
    chk(timers_on, 0);
    wake(3'h4, 1'b0);
    wo(A_CLK, 8'h00);
    go_sleep(3'h4);
    chk(xt_en, 0);
    wake(3'h4, 1'b0);
    $display("test oscillator done");
    for (i = 0; i < 8; i++)
    begin
      wo(A_LF, i[7:0]);
      chk(lf_sel, i);
      rchk(A_LF, i[7:0], 8'h07);
    end
    wo(A_LF, 8'h01);
    cyc(40);
    rchk(A_LF, 8'h49, 8'h7F);
    go_sleep(3'h4);
    chk(timers_on, 1);
    wake(3'h4, 1'b0);
    wo(A_LF, 8'h02);
    cyc(40);
    go_sleep(3'h2);
    chk(synth_en, 0);
    wake(3'h4, 1'b1);
    wo(A_LF, 8'h07);
    $display("test slow clock done");
    stop_test;
  end
endmodule // testbench
`default_nettype wire
